// ==== rtl/dbfh_cfg.svh ====
// Constants for the dual-bank flash host controller: register offsets, fields, timings.
// Assumes a 250 MHz system clock; included by the block map and host modules.
`ifndef DBFH_CFG_SVH
`define DBFH_CFG_SVH

`define DBFH_CLK_PERIOD_PS      4000
// Register word offsets (byte addresses on the Wishbone bus)
`define DBFH_REG_CTRL           8'h00
`define DBFH_REG_ADDR           8'h04
`define DBFH_REG_WDATA          8'h08
`define DBFH_REG_RDATA          8'h0C
`define DBFH_REG_STATUS         8'h10
`define DBFH_REG_BLOCK          8'h14
// Control register fields
`define DBFH_CTRL_GO            0
`define DBFH_CTRL_OP_LSB        1
`define DBFH_CTRL_OP_MSB        3
`define DBFH_CTRL_LOCK_N        4
// Status register fields
`define DBFH_STAT_BUSY          0
`define DBFH_STAT_DONE          1
`define DBFH_STAT_BANK          2
`define DBFH_STAT_PARAM         3
// Reset values
`define DBFH_CTRL_RST           32'h0000_0010
// Timing, in ns, not cycle counts
`define DBFH_T_SETUP_NS         20
`define DBFH_T_PULSE_NS         60
`define DBFH_T_READ_NS          100
`define DBFH_T_PAGE_NS          35
`define DBFH_T_HOLD_NS          20
`define DBFH_T_RSTPULSE_NS      100
`define DBFH_T_RSTREC_NS        1000
// Least times round up
`define DBFH_NS2CYC(ns)         (((ns) * 1000 + `DBFH_CLK_PERIOD_PS - 1) / `DBFH_CLK_PERIOD_PS)
// Memory map, word addresses
`define DBFH_BANK_BIT           18
`define DBFH_PARAM_TOP          19'h07FFF
`define DBFH_PARAM_SHIFT        12
`define DBFH_MAIN_SHIFT         15
`define DBFH_QUERY_LOW_MASK     19'h000FC
`define DBFH_QUERY_MAKER        2'h0
`define DBFH_QUERY_PART         2'h1
`define DBFH_QUERY_BLOCK        2'h2
`endif

// ==== rtl/dbfh_pkg.sv ====
// Types shared by the flash host controller modules.
// Assumes dbfh_cfg.svh is on the include path.
`default_nettype none
package dbfh_pkg;
   typedef enum logic [2:0] {
      DBFH_OP_READ,
      DBFH_OP_WRITE,
      DBFH_OP_PAGE,
      DBFH_OP_QUERY,
      DBFH_OP_RESET,
      DBFH_OP_CE_WRITE
   } dbfh_op_e;
   typedef logic [18:0] dbfh_addr_t;
   typedef logic [15:0] dbfh_data_t;
endpackage : dbfh_pkg
`default_nettype wire

// ==== rtl/dbfh_block_map.sv ====
// Decodes a word address into bank, block kind and block index (bottom-boot map).
// Assumes a 19-bit word address; purely combinational.
`include "dbfh_cfg.svh"
`default_nettype none
module dbfh_block_map
   import dbfh_pkg::*;
(
   input  wire dbfh_pkg::dbfh_addr_t addr_i,
   output logic                      bank_hi_o,
   output logic                      param_o,
   output logic [3:0]                block_o
);
   always_comb
   begin
      bank_hi_o = addr_i[`DBFH_BANK_BIT];
      param_o   = !bank_hi_o && (addr_i <= `DBFH_PARAM_TOP);
      if (param_o)
      begin
         block_o = {1'b0, addr_i[`DBFH_PARAM_SHIFT+2:`DBFH_PARAM_SHIFT]};
      end
      else
      begin
         block_o = {1'b0, addr_i[`DBFH_MAIN_SHIFT+2:`DBFH_MAIN_SHIFT]};
      end
   end
endmodule : dbfh_block_map
`default_nettype wire

// ==== rtl/dbfh_wait_cnt.sv ====
// Down-counter that times one phase of a flash bus cycle.
// Assumes load is a one-cycle pulse; done is high once the count has run out.
`default_nettype none
module dbfh_wait_cnt #(
   parameter int W = 10
) (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] count_i,
   output logic              done_o
);
   logic [W-1:0] cnt_r;
   if (W < 1)
   begin : g_bad_w
      $error("W must be at least 1");
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cnt_r <= '0;
      end
      else if (load_i)
      begin
         cnt_r <= count_i;
      end
      else if (cnt_r != '0)
      begin
         cnt_r <= cnt_r - 1'b1;
      end
   end
   assign done_o = (cnt_r == '0) && !load_i;
endmodule : dbfh_wait_cnt
`default_nettype wire

// ==== rtl/dbfh_host.sv ====
// Host controller that drives an asynchronous dual-bank x16 flash through its pins.
// Assumes Wishbone classic slave access, synchronous pin inputs and a 250 MHz clock.
//
// Chosen here: the Wishbone slave port and the address map.
`include "dbfh_cfg.svh"
`default_nettype none
module dbfh_host
   import dbfh_pkg::*;
#(
   parameter int RST_REC_CYC = `DBFH_NS2CYC(`DBFH_T_RSTREC_NS)
) (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   output dbfh_pkg::dbfh_addr_t      flash_addr_o,
   input  wire dbfh_pkg::dbfh_data_t data_io_i,
   output dbfh_pkg::dbfh_data_t      data_io_o,
   output logic                      data_io_oe_o,
   output logic                      chip_sel_n_o,
   output logic                      out_en_n_o,
   output logic                      wr_en_n_o,
   output logic                      rst_pd_n_o,
   output logic                      lock_n_o
);
   import dbfh_pkg::*;

   localparam int CNT_W    = 12;
   localparam int C_SETUP  = `DBFH_NS2CYC(`DBFH_T_SETUP_NS);
   localparam int C_PULSE  = `DBFH_NS2CYC(`DBFH_T_PULSE_NS);
   localparam int C_READ   = `DBFH_NS2CYC(`DBFH_T_READ_NS);
   localparam int C_PAGE   = `DBFH_NS2CYC(`DBFH_T_PAGE_NS);
   localparam int C_HOLD   = `DBFH_NS2CYC(`DBFH_T_HOLD_NS);
   localparam int C_RSTPLS = `DBFH_NS2CYC(`DBFH_T_RSTPULSE_NS);
   localparam logic [31:0] CTRL_RST = `DBFH_CTRL_RST;

   // Recovery count must fit the shared wait counter
   if (RST_REC_CYC < 1 || RST_REC_CYC >= (1 << CNT_W))
   begin : g_bad_rec
      $error("RST_REC_CYC out of range");
   end

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SETUP,
      ST_PULSE,
      ST_HOLD,
      ST_RST_LOW,
      ST_RST_REC
   } dbfh_state_e;

   dbfh_state_e      state_r;
   dbfh_op_e         op_r;
   dbfh_addr_t       addr_r;
   dbfh_data_t       wdata_r;
   logic [63:0]      rdata_r;
   logic [1:0]       word_r;
   logic             lock_n_r;
   logic             done_r;
   logic             go;
   logic             ld;
   logic [CNT_W-1:0] ld_cnt;
   logic             cnt_done;
   logic             bank_hi;
   logic             param;
   logic [3:0]       block;
   logic             wb_req;

   assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign go     = wb_req && wb_we_i && (wb_adr_i == `DBFH_REG_CTRL) && wb_sel_i[0]
                   && wb_dat_i[`DBFH_CTRL_GO] && (state_r == ST_IDLE);

   dbfh_wait_cnt #(.W(CNT_W)) u_cnt (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .load_i  (ld),
      .count_i (ld_cnt),
      .done_o  (cnt_done)
   );

   dbfh_block_map u_map (
      .addr_i    (addr_r),
      .bank_hi_o (bank_hi),
      .param_o   (param),
      .block_o   (block)
   );

   // Wishbone slave: ack one cycle after request, dropped the cycle after
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= wb_req;
         wb_dat_o <= 32'h0000_0000;
         if (wb_req && !wb_we_i)
         begin
            unique case (wb_adr_i)
               `DBFH_REG_CTRL:   wb_dat_o <= {27'h0, !lock_n_r, op_r, 1'b0};
               `DBFH_REG_ADDR:   wb_dat_o <= {13'h0, addr_r};
               `DBFH_REG_WDATA:  wb_dat_o <= {16'h0, wdata_r};
               `DBFH_REG_RDATA:  wb_dat_o <= rdata_r[31:0];
               `DBFH_REG_STATUS: wb_dat_o <= {28'h0, param, bank_hi, done_r,
                                              state_r != ST_IDLE};
               `DBFH_REG_BLOCK:  wb_dat_o <= {rdata_r[63:32]};
               default:          wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Software-written registers; only accepted while idle
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         op_r     <= dbfh_op_e'(CTRL_RST[`DBFH_CTRL_OP_MSB:`DBFH_CTRL_OP_LSB]);
         addr_r   <= '0;
         wdata_r  <= '0;
         lock_n_r <= !CTRL_RST[`DBFH_CTRL_LOCK_N];
      end
      else if (wb_req && wb_we_i && state_r == ST_IDLE)
      begin
         unique case (wb_adr_i)
            `DBFH_REG_CTRL:
            begin
               op_r     <= dbfh_op_e'(wb_dat_i[`DBFH_CTRL_OP_MSB:`DBFH_CTRL_OP_LSB]);
               lock_n_r <= !wb_dat_i[`DBFH_CTRL_LOCK_N];
            end
            `DBFH_REG_ADDR:  addr_r  <= wb_dat_i[18:0];
            `DBFH_REG_WDATA: wdata_r <= wb_dat_i[15:0];
            default:         ;
         endcase
      end
   end

   // Sequencer for the pin cycles
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_r <= ST_IDLE;
         word_r  <= 2'h0;
         ld      <= 1'b0;
         ld_cnt  <= '0;
      end
      else
      begin
         ld <= 1'b0;
         unique case (state_r)
            ST_IDLE:
            if (go)
            begin
               word_r <= 2'h0;
               ld     <= 1'b1;
               if (dbfh_op_e'(wb_dat_i[`DBFH_CTRL_OP_MSB:`DBFH_CTRL_OP_LSB]) == DBFH_OP_RESET)
               begin
                  state_r <= ST_RST_LOW;
                  ld_cnt  <= CNT_W'(C_RSTPLS);
               end
               else
               begin
                  state_r <= ST_SETUP;
                  ld_cnt  <= CNT_W'(C_SETUP);
               end
            end
            ST_SETUP:
            if (cnt_done && !ld)
            begin
               state_r <= ST_PULSE;
               ld      <= 1'b1;
               if (op_r == DBFH_OP_WRITE || op_r == DBFH_OP_CE_WRITE)
               begin
                  ld_cnt <= CNT_W'(C_PULSE);
               end
               else
               begin
                  ld_cnt <= CNT_W'(C_READ);
               end
            end
            ST_PULSE:
            if (cnt_done && !ld)
            begin
               if (op_r == DBFH_OP_PAGE && word_r != 2'h3)
               begin
                  word_r <= word_r + 2'h1;
                  ld     <= 1'b1;
                  ld_cnt <= CNT_W'(C_PAGE);
               end
               else
               begin
                  state_r <= ST_HOLD;
                  ld      <= 1'b1;
                  ld_cnt  <= CNT_W'(C_HOLD);
               end
            end
            ST_HOLD:
            if (cnt_done && !ld)
            begin
               state_r <= ST_IDLE;
            end
            ST_RST_LOW:
            if (cnt_done && !ld)
            begin
               state_r <= ST_RST_REC;
               ld      <= 1'b1;
               ld_cnt  <= CNT_W'(RST_REC_CYC);
            end
            ST_RST_REC:
            if (cnt_done && !ld)
            begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Read data capture at the end of each read, page or query access, packed per page word
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rdata_r <= '0;
      end
      else if (state_r == ST_PULSE && cnt_done && !ld && op_r != DBFH_OP_WRITE
               && op_r != DBFH_OP_CE_WRITE)
      begin
         rdata_r[word_r*16 +: 16] <= data_io_i;
      end
   end

   // Done flag: set by cycle end wins over clear by a new start
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         done_r <= 1'b0;
      end
      else if ((state_r == ST_HOLD || state_r == ST_RST_REC) && cnt_done && !ld)
      begin
         done_r <= 1'b1;
      end
      else if (go)
      begin
         done_r <= 1'b0;
      end
   end

   // Pin drive, all registered
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         flash_addr_o <= '0;
         data_io_o    <= '0;
         data_io_oe_o <= 1'b0;
         chip_sel_n_o <= 1'b1;
         out_en_n_o   <= 1'b1;
         wr_en_n_o    <= 1'b1;
         rst_pd_n_o   <= 1'b0;
         lock_n_o     <= !CTRL_RST[`DBFH_CTRL_LOCK_N];
      end
      else
      begin
         lock_n_o   <= lock_n_r;
         rst_pd_n_o <= (state_r != ST_RST_LOW);
         if (op_r == DBFH_OP_QUERY)
         begin
            flash_addr_o <= addr_r & ~`DBFH_QUERY_LOW_MASK;
         end
         else
         begin
            flash_addr_o <= {addr_r[18:2], (op_r == DBFH_OP_PAGE) ? word_r : addr_r[1:0]};
         end
         data_io_o <= wdata_r;
         unique case (state_r)
            ST_SETUP, ST_PULSE:
            begin
               chip_sel_n_o <= (op_r == DBFH_OP_CE_WRITE) ? (state_r != ST_PULSE) : 1'b0;
               if (op_r == DBFH_OP_WRITE || op_r == DBFH_OP_CE_WRITE)
               begin
                  out_en_n_o   <= 1'b1;
                  data_io_oe_o <= 1'b1;
                  wr_en_n_o    <= (op_r == DBFH_OP_CE_WRITE) ? 1'b0
                                  : (state_r != ST_PULSE);
               end
               else
               begin
                  out_en_n_o   <= 1'b0;
                  data_io_oe_o <= 1'b0;
                  wr_en_n_o    <= 1'b1;
               end
            end
            ST_HOLD:
            begin
               chip_sel_n_o <= 1'b1;
               wr_en_n_o    <= 1'b1;
               out_en_n_o   <= 1'b1;
               data_io_oe_o <= (op_r == DBFH_OP_WRITE || op_r == DBFH_OP_CE_WRITE);
            end
            default:
            begin
               chip_sel_n_o <= 1'b1;
               wr_en_n_o    <= 1'b1;
               out_en_n_o   <= 1'b1;
               data_io_oe_o <= 1'b0;
            end
         endcase
      end
   end
endmodule : dbfh_host
`default_nettype wire

// ==== testbench/dbfh_host_asserts.sv ====
// Pin and bus-answer checks for the flash host controller.
// Assumes it is bound onto dbfh_host; one clock domain.
`default_nettype none
module dbfh_host_asserts
   import dbfh_pkg::*;
(
   input wire logic                 clk_i,
   input wire logic                 rst_i,
   input wire logic                 wb_cyc_i,
   input wire logic                 wb_stb_i,
   input wire logic                 wb_ack_o,
   input wire dbfh_pkg::dbfh_addr_t flash_addr_o,
   input wire dbfh_pkg::dbfh_data_t data_io_o,
   input wire logic                 data_io_oe_o,
   input wire logic                 chip_sel_n_o,
   input wire logic                 out_en_n_o,
   input wire logic                 wr_en_n_o,
   input wire logic                 rst_pd_n_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   wire logic wr_act = !chip_sel_n_o && !wr_en_n_o;
   sequence s_wr_start;
      $rose(wr_act);
   endsequence
   sequence s_wr_end;
      $fell(wr_act);
   endsequence
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_RD_NO_DRIVE: assert property (!chip_sel_n_o && !out_en_n_o |-> !data_io_oe_o)
      else $error("host drives data during read");
   AST_WR_QUAL: assert property (wr_act |-> out_en_n_o && rst_pd_n_o)
      else $error("write with output enable or reset low");
   AST_WR_STABLE: assert property (wr_act && $past(wr_act) |-> $stable(flash_addr_o))
      else $error("address moved inside write");
   AST_WR_HOLD: assert property (s_wr_end |-> data_io_oe_o && $stable(data_io_o))
      else $error("data not held at write end");
   AST_WR_WIDTH: assert property (s_wr_start |-> wr_act [*8])
      else $error("write pulse too short");
   AST_RST_WIDTH: assert property ($fell(rst_pd_n_o) |-> !rst_pd_n_o [*8])
      else $error("reset pulse too short");
endmodule : dbfh_host_asserts
`default_nettype wire

// ==== testbench/dbfh_flash_model.sv ====
// Behavioural x16 flash seen through its pins, sampled on the host clock.
// Assumes unwritten words read as address xor 3C3C.
`default_nettype none
module dbfh_flash_model #(
   parameter bit PD_EN = 1'b0
) (
   input  wire logic        clk_i,
   input  wire logic [18:0] addr_i,
   input  wire logic [15:0] dq_i,
   input  wire logic        ce_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic        rst_pd_n_i,
   input  wire logic        lock_n_i,
   output logic      [15:0] dq_o,
   output logic             dq_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [0:524287];
   logic [18:0] addr_l;
   logic [15:0] data_l;
   logic [15:0] last_r;
   logic [1:0]  wcnt;
   logic        wact;
   logic [1:0]  busy_r;
   logic        tog_r;
   logic        pd_st;
   logic [15:0] stat;
   assign wact = !ce_n_i && !we_n_i && oe_n_i && rst_pd_n_i;
   assign dq_oe_o = !ce_n_i && !oe_n_i && rst_pd_n_i;
   assign pd_st = PD_EN && !rst_pd_n_i;
   // Program status word: poll inverts data bit 7, toggles on 6 and 2, no error
   assign stat = {8'h00, ~data_l[7], tog_r, 1'b0, 2'h0, tog_r, 2'h0};
   // Released bus shows the inverse of the last word
   assign dq_o = dq_oe_o ? ((busy_r != 2'h0) ? stat : mem[addr_i]) : ~last_r;
   initial
   begin
      wcnt = 2'h0;
      last_r = 16'h0;
      busy_r = 2'h0;
      tog_r = 1'b0;
      for (int i = 0; i < 524288; i++)
         mem[i] = i[15:0] ^ 16'h3C3C;
   end
   always @(posedge clk_i)
   begin
      if (pd_st)
         last_r <= 16'h0;
      else if (dq_oe_o)
         last_r <= dq_o;
      if (dq_oe_o && busy_r != 2'h0)
         tog_r <= ~tog_r;
      if (!rst_pd_n_i)
         wcnt <= 2'h0;
      else if (wact)
      begin
         if (wcnt == 2'h0)
            addr_l <= addr_i;
         data_l <= dq_i;
         if (wcnt != 2'h3)
            wcnt <= wcnt + 2'h1;
      end
      else
      begin
         if (wcnt > 2'h1 && lock_n_i)
            mem[addr_l] <= data_l;
         wcnt <= 2'h0;
      end
   end
   // Short program busy time after a landed write
   always @(posedge clk_i)
   begin
      if (!rst_pd_n_i)
         busy_r <= 2'h0;
      else if (!wact && wcnt > 2'h1 && lock_n_i)
         busy_r <= 2'h3;
      else if (busy_r != 2'h0)
         busy_r <= busy_r - 2'h1;
   end
endmodule : dbfh_flash_model
`default_nettype wire

// ==== testbench/test_dbfh_host.sv ====
// Self-checking bench: Wishbone orders to the host, flash model on the pins.
// Assumes the checker and flash model are compiled first.
`default_nettype none
module test_dbfh_host;
   timeunit 1ns;
   timeprecision 1ps;
   logic                 clk_i, rst_i, cyc, stb, we;
   logic [7:0]           adr;
   logic [31:0]          wdat, q, st;
   wire logic [31:0]     rdat;
   wire logic            ack, oe, ce_n, oen_n, we_n, rp_n, lk_n, mdrv;
   dbfh_pkg::dbfh_addr_t faddr;
   dbfh_pkg::dbfh_data_t dq_o, mdq;
   wire logic [15:0]     dq = oe ? dq_o : mdq;
   int                   errors, checks_done;
   logic [18:0]          map_a [6] = '{19'h00000, 19'h07FFF, 19'h08000, 19'h3FFFF,
                                       19'h40000, 19'h7FFFF};
   dbfh_host #(.RST_REC_CYC(2)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .flash_addr_o(faddr), .data_io_i(dq),
      .data_io_o(dq_o), .data_io_oe_o(oe), .chip_sel_n_o(ce_n), .out_en_n_o(oen_n),
      .wr_en_n_o(we_n), .rst_pd_n_o(rp_n), .lock_n_o(lk_n));
   dbfh_flash_model u_flash (.clk_i(clk_i), .addr_i(faddr), .dq_i(dq), .ce_n_i(ce_n),
      .oe_n_i(oen_n), .we_n_i(we_n), .rst_pd_n_i(rp_n), .lock_n_i(lk_n), .dq_o(mdq),
      .dq_oe_o(mdrv));
   function automatic logic [15:0] pat(input logic [18:0] a);
      return a[15:0] ^ 16'h3C3C;
   endfunction : pat
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 50)
      begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 50)
         errors++;
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic op(input logic [2:0] code, input logic [18:0] a, input logic [15:0] d);
      int n;
      n = 0;
      wb(1'b1, 8'h04, {13'h0, a}, q);
      wb(1'b1, 8'h08, {16'h0, d}, q);
      wb(1'b1, 8'h00, {28'h0, code, 1'b1}, q);
      st = 32'h0;
      while (st[1] !== 1'b1 && n < 500)
      begin
         wb(1'b0, 8'h10, 32'h0, st);
         n++;
      end
      chk("done", 32'h1, {31'h0, st[1]});
   endtask : op
   task end_of_test;
      if (errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   always @(posedge clk_i)
   begin
      if (oe === 1'b1 && mdrv === 1'b1)
         chk("bus_clash", 32'h0, 32'h1);
   end
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial
   begin
      #80000;
      errors++;
      end_of_test();
   end
   initial
   begin
      {cyc, stb, we, adr, wdat, errors, checks_done} = '0;
      rst_i = 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, 8'h00, 32'h0, q);
      chk("ctrl_rst", 32'h10, q);
      chk("lock_rst", 32'h0, {31'h0, lk_n});
      chk("rp_idle", 32'h1, {31'h0, rp_n});
      wb(1'b0, 8'h1C, 32'h0, q);
      chk("unmapped", 32'h0, q);
      op(3'h1, 19'h12345, 16'hA5C3);
      chk("lock_off", 32'h1, {31'h0, lk_n});
      op(3'h0, 19'h12345, 16'h0);
      wb(1'b0, 8'h0C, 32'h0, q);
      chk("we_write", 32'hA5C3, {16'h0, q[15:0]});
      op(3'h5, 19'h40001, 16'h5A3C);
      op(3'h0, 19'h40001, 16'h0);
      wb(1'b0, 8'h0C, 32'h0, q);
      chk("ce_write", 32'h5A3C, {16'h0, q[15:0]});
      foreach (map_a[i])
      begin
         op(3'h0, map_a[i], 16'h0);
         chk("map", {30'h0, map_a[i] <= 19'h07FFF, map_a[i][18]}, {30'h0, st[3:2]});
      end
      op(3'h2, 19'h08004, 16'h0);
      wb(1'b0, 8'h0C, 32'h0, q);
      chk("page_lo", {pat(19'h08005), pat(19'h08004)}, q);
      wb(1'b0, 8'h14, 32'h0, q);
      chk("page_hi", {pat(19'h08007), pat(19'h08006)}, q);
      op(3'h3, 19'h000FE, 16'h0);
      chk("query_addr", 32'h2, {13'h0, faddr});
      wb(1'b0, 8'h0C, 32'h0, q);
      chk("query_data", {16'h0, pat(19'h00002)}, {16'h0, q[15:0]});
      op(3'h4, 19'h0, 16'h0);
      chk("rp_back", 32'h1, {31'h0, rp_n});
      op(3'h0, 19'h12345, 16'h0);
      wb(1'b0, 8'h0C, 32'h0, q);
      chk("after_rst", 32'hA5C3, {16'h0, q[15:0]});
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b0, 8'h00, 32'h0, q);
      chk("ctrl_rst2", 32'h10, q);
      chk("lock_rst2", 32'h0, {31'h0, lk_n});
      chk("rp_idle2", 32'h1, {31'h0, rp_n});
      end_of_test();
   end
endmodule : test_dbfh_host
bind dbfh_host dbfh_host_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .flash_addr_o(flash_addr_o),
   .data_io_o(data_io_o), .data_io_oe_o(data_io_oe_o), .chip_sel_n_o(chip_sel_n_o),
   .out_en_n_o(out_en_n_o), .wr_en_n_o(wr_en_n_o), .rst_pd_n_o(rst_pd_n_o));
`default_nettype wire
